//--- clock_sync_serial_port_bench.sv
// bench for the serial port: register bus driver, queue model, far ic.
// assumes csp_serial_port, csp_far_ic and the checker are compiled first.
module clock_sync_serial_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [4:0]  avs_address_i = 5'h00;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0]  avs_byteenable_i = 4'hf;
  logic        hs_drv = 1'b0;  // far level on handshake
  logic        ext_sclk = 1'b1;  // far-supplied transfer clock
  logic        ext_on = 1'b0;    // far side owns the clock
  logic        pol = 1'b0;
  logic        msb = 1'b0;
  logic [7:0]  send = 8'h00;
  logic [7:0]  b;
  logic [31:0] rd;
  wire  [31:0] avs_readdata_o;
  wire         avs_waitrequest_o, sclk_o, sclk_oe_o, txd_o, rxd, hs_o, hs_oe_o, irq_o;
  wire  [7:0]  got;
  wire         sclk_pin = sclk_oe_o ? sclk_o : ext_sclk;
  wire         hs_pin = hs_oe_o ? hs_o : hs_drv;
  int fails = 0;
  int tests_run = 0;
  int seed = 75;
  int i;
  int q[$];  // expected received words
  int pre_t[4] = '{0, 1, 2, 0};
  int n_t[4] = '{2, 0, 0, 1};

  always #5 clk_i = ~clk_i;

  csp_serial_port dut (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .sclk_i(sclk_pin), .sclk_o(sclk_o),
    .sclk_oe_o(sclk_oe_o), .rxd_i(rxd), .txd_o(txd_o), .hs_i(hs_pin), .hs_o(hs_o),
    .hs_oe_o(hs_oe_o), .irq_o(irq_o));
  csp_far_ic far (.clk_i(clk_i), .sclk_i(sclk_pin), .oe_i(sclk_oe_o | ext_on), .txd_i(txd_o),
    .pol_i(pol), .msb_i(msb), .send_i(send), .rxd_o(rxd), .got_o(got));

  task chk(input [31:0] s, input [31:0] e);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // one avalon transfer, held until waitrequest is low
  task bus(input w, input [4:0] a, input [31:0] d);
    int k;
    k = 0;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    @(negedge clk_i);
    while (avs_waitrequest_o !== 1'b0) begin
      k++;
      if (k > 20) begin fails++; results; end
      @(negedge clk_i);
    end
    @(posedge clk_i);  // edge that samples waitrequest low
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task wait_bit(input int n);
    for (int k = 0; k < 400; k++) begin
      bus(1'b0, 5'h10, 0);
      if (rd[n] === 1'b1) return;
    end
    fails++;
    results;
  endtask
  // send one word, far side answers with a random one
  task word(input [7:0] d);
    b = 8'($random(seed));
    send <= b;
    q.push_back(b);
    bus(1'b1, 5'h08, {24'h0, d});
    wait_bit(0);
    chk(got, d);
    bus(1'b1, 5'h10, 32'h3);
  endtask

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    bus(1'b0, 5'h00, 0);
    chk(rd, 32'h80);
    bus(1'b0, 5'h10, 0);
    chk(rd, 0);
    bus(1'b1, 5'h1c, 32'hff);
    bus(1'b0, 5'h1c, 0);
    chk(rd, 0);
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
      bus(1'b1, 5'h00, 32'h80 | pre_t[i] << 4 | i[0] << 8 | i[1] << 9);
      pol <= i[0];
      msb <= i[1];
      bus(1'b1, 5'h04, n_t[i]);
      bus(1'b1, 5'h00, 32'h1881 | pre_t[i] << 4 | i[0] << 8 | i[1] << 9);
      word(8'($random(seed)));
      bus(1'b0, 5'h0c, 0);
      chk(rd, q.pop_front());
    end
    $display("test word formats done");
    bus(1'b1, 5'h00, 32'h80);
    pol <= 1'b0;
    msb <= 1'b0;
    bus(1'b1, 5'h04, 0);
    bus(1'b1, 5'h00, 32'h18a1);
    bus(1'b1, 5'h14, 32'h4);
    word(8'h3c);
    word(8'hc3);
    bus(1'b0, 5'h10, 0);
    chk(rd[2], 1);
    bus(1'b0, 5'h0c, 0);
    chk(rd[8], 1);
    q.delete();
    @(posedge clk_i);
    chk(irq_o, 1);
    bus(1'b1, 5'h14, 0);
    @(posedge clk_i);
    chk(irq_o, 0);
    bus(1'b1, 5'h14, 32'h4);
    @(posedge clk_i);
    chk(irq_o, 1);
    bus(1'b1, 5'h10, 32'h4);
    @(posedge clk_i);
    chk(irq_o, 0);
    $display("test overrun and interrupt done");
    bus(1'b1, 5'h08, 32'ha5);
    repeat (40) @(posedge clk_i);
    bus(1'b1, 5'h00, 32'h18a0);
    bus(1'b0, 5'h10, 0);
    chk(rd[10:8], 0);
    chk(sclk_oe_o, 0);
    bus(1'b1, 5'h00, 32'h18a1);
    word(8'h96);
    bus(1'b0, 5'h0c, 0);
    chk(rd, q.pop_front());
    $display("test abort done");
    ext_on <= 1'b1;
    bus(1'b1, 5'h00, 32'h1889);
    b = 8'($random(seed));
    send <= b;
    q.push_back(b);
    bus(1'b1, 5'h08, 32'h5a);
    for (i = 0; i < 16; i++) begin
      repeat (4) @(posedge clk_i);
      ext_sclk <= ~ext_sclk;
    end
    wait_bit(0);
    chk(got, 8'h5a);
    bus(1'b1, 5'h10, 32'h3);
    bus(1'b0, 5'h0c, 0);
    chk(rd, q.pop_front());
    ext_on <= 1'b0;
    $display("test external clock done");
    bus(1'b1, 5'h04, 1);
    hs_drv <= 1'b1;
    bus(1'b1, 5'h00, 32'h1801);
    bus(1'b1, 5'h08, 32'h77);
    repeat (30) @(posedge clk_i);
    bus(1'b0, 5'h10, 0);
    chk(rd[9:8], 2'h2);
    hs_drv <= 1'b0;
    wait_bit(0);
    chk(got, 8'h77);
    bus(1'b1, 5'h10, 32'h3);
    bus(1'b0, 5'h0c, 0);
    $display("test clear to send done");
    b = 8'($random(seed));
    send <= b;
    q.push_back(b);
    bus(1'b1, 5'h00, 32'h1441);
    bus(1'b0, 5'h0c, 0);
    chk(hs_oe_o, 1);
    wait_bit(1);
    bus(1'b0, 5'h0c, 0);
    chk(rd, q.pop_front());
    bus(1'b1, 5'h00, 32'h80);
    $display("test continuous receive done");
    results;
  end
endmodule // clock_sync_serial_port_bench

bind csp_serial_port csp_serial_port_props u_props (.clk_i(clk_i), .rst_i(rst_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .sclk_i(sclk_i), .sclk_o(sclk_o), .sclk_oe_o(sclk_oe_o), .rxd_i(rxd_i),
  .txd_o(txd_o), .hs_i(hs_i), .hs_o(hs_o), .hs_oe_o(hs_oe_o), .irq_o(irq_o));

//--- csp_defines.vh
// constants for the clock-synchronous serial port: register map,
// field positions, reset values and mode codes.
// assumes inclusion by bare name from each design file.
`ifndef CSP_DEFINES_VH
`define CSP_DEFINES_VH

// ----------------------------------------------------------------
// register byte offsets (word aligned)
// ----------------------------------------------------------------
`define CSP_OFS_CTRL      5'h00
`define CSP_OFS_RATE      5'h04
`define CSP_OFS_TXBUF     5'h08
`define CSP_OFS_RXBUF     5'h0c
`define CSP_OFS_STAT      5'h10
`define CSP_OFS_MASK      5'h14
`define CSP_OFS_PORT      5'h18

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define CSP_CTRL_MODE     2:0
`define CSP_CTRL_EXTCLK   3
`define CSP_CTRL_PRE      5:4
`define CSP_CTRL_RTSSEL   6
`define CSP_CTRL_HSDIS    7
`define CSP_CTRL_POL      8
`define CSP_CTRL_MSB      9
`define CSP_CTRL_CONT     10
`define CSP_CTRL_TXEN     11
`define CSP_CTRL_RXEN     12
`define CSP_CTRL_W        13
`define CSP_CTRL_RST      13'h0080

// ----------------------------------------------------------------
// mode codes and prescaler choices
// ----------------------------------------------------------------
`define CSP_MODE_OFF      3'h0
`define CSP_MODE_SYNC     3'h1
`define CSP_PRE_DIV1      2'h0
`define CSP_PRE_DIV8      2'h1
`define CSP_PRE_DIV32     2'h2
`define CSP_PRE8_LAST     3'h7
`define CSP_PRE32_LAST    5'h1f

// ----------------------------------------------------------------
// status / mask bits, receive word layout, port register bits
// ----------------------------------------------------------------
`define CSP_ST_TXDONE     0
`define CSP_ST_RXDONE     1
`define CSP_ST_OVR        2
`define CSP_ST_W          3
`define CSP_ST_BUSY       8
`define CSP_ST_TXPEND     9
`define CSP_ST_RXFULL     10
`define CSP_RX_OVR        8
`define CSP_PORT_OUT      0
`define CSP_PORT_DIR      1
`define CSP_PORT_PIN      2

// ----------------------------------------------------------------
// word shape and bit counts
// ----------------------------------------------------------------
`define CSP_BITS_W        4
`define CSP_BIT_SEVENTH   4'h6
`define CSP_BIT_LAST      4'h7
`define CSP_ZERO_BITS     4'h0
`define CSP_RATE_RST      8'h00

`endif

//--- csp_far_ic.sv
// far-side ic model: clocked by the port, exchanges one word per frame.
// assumes pol and order are changed only while the port is disabled.
module csp_far_ic (
  // clock and pins
  input  wire logic       clk_i,
  input  wire logic       sclk_i,
  input  wire logic       oe_i,
  input  wire logic       txd_i,
  // format
  input  wire logic       pol_i,
  input  wire logic       msb_i,
  // data
  input  wire logic [7:0] send_i,
  output logic            rxd_o = 1'b0,
  output logic      [7:0] got_o = 8'h00
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       prev_s;  // last clock level
  logic       prev_oe; // last drive state
  logic       live;    // inside a frame
  logic [2:0] cnt;     // bits sampled
  logic [2:0] idx;     // bit position
  // sample on one edge, shift out on the other
  always @(posedge clk_i) begin
    prev_s  <= sclk_i;
    prev_oe <= oe_i;
    idx = msb_i ? 3'h7 - cnt : cnt;
    if (!(oe_i && prev_oe)) begin
      cnt   <= 3'h0;
      live  <= 1'b0;
      rxd_o <= ~rxd_o;  // no stable level off frame
    end else if (sclk_i != prev_s) begin
      if (sclk_i == !pol_i) begin
        got_o[idx] <= txd_i;
        cnt <= cnt + 3'h1;
        if (cnt == 3'h7) live <= 1'b0;
      end else begin
        rxd_o <= send_i[idx];
        live  <= 1'b1;
      end
    end else if (!live) rxd_o <= ~rxd_o;
  end
endmodule // csp_far_ic

//--- csp_rate_div.v
// bit-rate divider: prescaler from the main clock, then an n+1 divider.
// assumes run is low between words so counters restart each word.
`include "csp_defines.vh"

module csp_rate_div (
  // clock and reset
  input  wire       clk_i,
  input  wire       rst_i,
  // control
  input  wire       run_i,     // count only while shifting
  input  wire [1:0] pre_i,     // prescaler choice
  input  wire [7:0] n_i,       // divide by n plus one
  // output
  output wire       tick_o     // one pulse per divider period
);

  reg  [4:0] pre_cnt;          // prescaler counter
  reg  [7:0] div_cnt;          // rate divider counter
  reg        pre_tick;         // selected prescaled clock

  // ----------------------------------------------------------------
  // prescaled clock selection
  // ----------------------------------------------------------------
  always @* begin
    case (pre_i)
      `CSP_PRE_DIV1:  pre_tick = 1'b1;
      `CSP_PRE_DIV8:  pre_tick = (pre_cnt[2:0] == `CSP_PRE8_LAST);
      `CSP_PRE_DIV32: pre_tick = (pre_cnt == `CSP_PRE32_LAST);
      default:        pre_tick = 1'b0;  // inhibited choice, no clock
    endcase
  end

  assign tick_o = run_i & pre_tick & (div_cnt == n_i);

  // ----------------------------------------------------------------
  // counters, cleared while idle
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      pre_cnt <= 5'h00;
      div_cnt <= 8'h00;
    end else begin
      pre_cnt <= pre_cnt + 5'h01;
      if (pre_tick) begin
        div_cnt <= tick_o ? 8'h00 : div_cnt + 8'h01;
      end
    end
  end

endmodule // csp_rate_div

//--- csp_serial_port.v
// clock-synchronous serial port with an avalon-mm register slave.
// assumes pins synchronous to clk_i and an external clock far slower.
//
// Notes on behaviour
// - every transfer is one eight-bit word
// - internal link clock is half divider rate
// - divider source: main clock /1, /8, /32
// - external clock pin paces shifting exactly
// - overrun flagged at seventh bit, unread word
// - off mode reinitialises the receive path
// - off mode discards pending transmit state
// - clear-to-send low sampled only at start
// - request-to-send low when ready, high at falling
// - handshake pin: port, cts, or rts
// - polarity picks sampling and output edges
// - bit order lsb first or msb first
// - normal: tx write arms; continuous: rx read
// - only mode 001 runs, 000 disables
// - divider divides by setting plus one
//
// Chosen here: the register offsets and the Avalon-MM interface to the registers.
`include "csp_defines.vh"

module csp_serial_port (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // avalon-mm slave
  input  wire [4:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  input  wire [3:0]  avs_byteenable_i,
  output reg  [31:0] avs_readdata_o,
  output wire        avs_waitrequest_o,
  // transfer clock pin
  input  wire        sclk_i,
  output wire        sclk_o,
  output wire        sclk_oe_o,
  // data pins
  input  wire        rxd_i,
  output wire        txd_o,
  // handshake pin
  input  wire        hs_i,
  output wire        hs_o,
  output wire        hs_oe_o,
  // interrupt
  output wire        irq_o
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  reg  [`CSP_CTRL_W-1:0] ctrl;     // control register
  reg  [7:0]             rate;     // divider setting
  reg  [7:0]             txbuf;    // transmit buffer
  reg  [7:0]             rxbuf;    // receive buffer
  reg  [`CSP_ST_W-1:0]   stat;     // sticky events
  reg  [`CSP_ST_W-1:0]   mask;     // interrupt mask
  reg  [1:0]             port;     // general port out and dir
  reg                    ack;      // bus answer cycle
  reg                    tx_pend;  // tx buffer holds a word
  reg                    rx_arm;   // reception armed by read
  reg                    rx_full;  // unread word in rxbuf
  reg                    ovr;      // overrun flag of rxbuf
  reg                    busy;     // word in flight
  reg  [7:0]             tx_sh;    // transmit shifter
  reg  [7:0]             rx_sh;    // receive shifter
  reg  [`CSP_BITS_W-1:0] nbits;    // bits sampled so far
  reg                    sclk_q;   // internal clock level
  reg                    sclk_d;   // previous external level
  reg                    rts_n;    // request-to-send level
  reg                    txd_q;    // data out level
  reg  [`CSP_ST_W-1:0]   ev;       // event pulses this cycle

  wire       mode_on  = (ctrl[`CSP_CTRL_MODE] == `CSP_MODE_SYNC);
  wire       ext_clk  = ctrl[`CSP_CTRL_EXTCLK];
  wire       pol      = ctrl[`CSP_CTRL_POL];
  wire       msb      = ctrl[`CSP_CTRL_MSB];
  wire       cont     = ctrl[`CSP_CTRL_CONT];
  wire       tx_en    = ctrl[`CSP_CTRL_TXEN];
  wire       rx_en    = ctrl[`CSP_CTRL_RXEN];
  wire       hs_dis   = ctrl[`CSP_CTRL_HSDIS];
  wire       rts_sel  = ctrl[`CSP_CTRL_RTSSEL];
  wire       idle_lvl = ~pol;      // idle high when sampling on rise
  wire       tick;                 // divider output pulse
  wire       req      = avs_read_i | avs_write_i;
  wire       wr_go    = avs_write_i & ack;
  wire       rd_go    = avs_read_i & ack;
  wire       rxrd_go  = rd_go & (avs_address_i == `CSP_OFS_RXBUF);
  wire       be0      = avs_byteenable_i[0];
  wire       be1      = avs_byteenable_i[1];

  // ----------------------------------------------------------------
  // helper: write hit on one register offset
  // ----------------------------------------------------------------
  function wr_hit;
    input [4:0] ofs;
    begin
      wr_hit = wr_go & (avs_address_i == ofs);
    end
  endfunction

  // ----------------------------------------------------------------
  // bit-rate divider
  // ----------------------------------------------------------------
  csp_rate_div u_div (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .run_i  (busy & ~ext_clk),
    .pre_i  (ctrl[`CSP_CTRL_PRE]),
    .n_i    (rate),
    .tick_o (tick)
  );

  // ----------------------------------------------------------------
  // transfer clock edges from either source
  // ----------------------------------------------------------------
  wire int_fall = tick & sclk_q;        // internal clock going low
  wire int_rise = tick & ~sclk_q;       // internal clock going high
  wire ext_fall = sclk_d & ~sclk_i;
  wire ext_rise = ~sclk_d & sclk_i;
  wire fall_ev  = ext_clk ? ext_fall : int_fall;
  wire rise_ev  = ext_clk ? ext_rise : int_rise;
  wire samp_ev  = busy & (pol ? fall_ev : rise_ev);
  wire shft_ev  = busy & (pol ? rise_ev : fall_ev);

  // ----------------------------------------------------------------
  // start condition
  // ----------------------------------------------------------------
  wire cts_ok   = hs_dis | rts_sel | ~hs_i;
  wire want     = cont ? (rx_en & rx_arm)
                       : (tx_en & tx_pend);
  wire start    = mode_on & ~busy & want & cts_ok;
  wire last_bit = samp_ev & (nbits == `CSP_BIT_LAST);
  wire tx_wr    = wr_hit(`CSP_OFS_TXBUF) & be0;     // new word this cycle

  // ----------------------------------------------------------------
  // bus answer: one wait cycle, then ack
  // ----------------------------------------------------------------
  assign avs_waitrequest_o = req & ~ack;

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end

  // ----------------------------------------------------------------
  // read data, registered in the wait cycle
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      avs_readdata_o <= 32'h00000000;
    end else if (avs_read_i & ~ack) begin
      case (avs_address_i)
        `CSP_OFS_CTRL:  avs_readdata_o <= {19'h00000, ctrl};
        `CSP_OFS_RATE:  avs_readdata_o <= {24'h000000, rate};
        `CSP_OFS_TXBUF: avs_readdata_o <= {24'h000000, txbuf};
        `CSP_OFS_RXBUF: avs_readdata_o <= {23'h000000, ovr, rxbuf};
        `CSP_OFS_STAT:  avs_readdata_o <= {21'h000000, rx_full, tx_pend,
                                           busy, 5'h00, stat};
        `CSP_OFS_MASK:  avs_readdata_o <= {29'h00000000, mask};
        `CSP_OFS_PORT:  avs_readdata_o <= {29'h00000000, hs_i, port};
        default:        avs_readdata_o <= 32'h00000000; // unmapped
      endcase
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= `CSP_CTRL_RST;
      rate <= `CSP_RATE_RST;
      mask <= {`CSP_ST_W{1'b0}};
      port <= 2'h0;
    end else begin
      if (wr_hit(`CSP_OFS_CTRL) && be0) begin
        ctrl[7:0] <= avs_writedata_i[7:0];
      end
      if (wr_hit(`CSP_OFS_CTRL) && be1) begin
        ctrl[`CSP_CTRL_W-1:8] <= avs_writedata_i[`CSP_CTRL_W-1:8];
      end
      if (wr_hit(`CSP_OFS_RATE) && be0) begin
        rate <= avs_writedata_i[7:0];
      end
      if (wr_hit(`CSP_OFS_MASK) && be0) begin
        mask <= avs_writedata_i[`CSP_ST_W-1:0];
      end
      if (wr_hit(`CSP_OFS_PORT) && be0) begin
        port <= avs_writedata_i[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // sticky status: set wins over write-one-clear
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      stat <= {`CSP_ST_W{1'b0}};
    end else if (wr_hit(`CSP_OFS_STAT) && be0) begin
      stat <= (stat & ~avs_writedata_i[`CSP_ST_W-1:0]) | ev;
    end else begin
      stat <= stat | ev;
    end
  end

  assign irq_o = |(stat & mask);

  // ----------------------------------------------------------------
  // transfer engine: buffers, shifters, clock, handshake
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      txbuf   <= 8'h00;
      rxbuf   <= 8'h00;
      tx_pend <= 1'b0;
      rx_arm  <= 1'b0;
      rx_full <= 1'b0;
      ovr     <= 1'b0;
      busy    <= 1'b0;
      tx_sh   <= 8'h00;
      rx_sh   <= 8'h00;
      nbits   <= `CSP_ZERO_BITS;
      sclk_q  <= 1'b1;
      sclk_d  <= 1'b1;
      rts_n   <= 1'b1;
      txd_q   <= 1'b1;
      ev      <= {`CSP_ST_W{1'b0}};
    end else begin
      sclk_d <= sclk_i;                 // external clock history
      ev     <= {`CSP_ST_W{1'b0}};
      if (!mode_on) begin
        // channel off: drop all transfer state
        tx_pend <= 1'b0;
        rx_arm  <= 1'b0;
        rx_full <= 1'b0;
        ovr     <= 1'b0;
        busy    <= 1'b0;
        nbits   <= `CSP_ZERO_BITS;
        sclk_q  <= idle_lvl;
        rts_n   <= 1'b1;
        txd_q   <= 1'b1;
      end else begin
        // buffer writes and the arming read
        if (wr_hit(`CSP_OFS_TXBUF) && be0) begin
          txbuf   <= avs_writedata_i[7:0];
          tx_pend <= 1'b1;
        end
        if (rxrd_go) begin
          rx_full <= 1'b0;
          ovr     <= 1'b0;
          rx_arm  <= 1'b1;
        end
        // request-to-send: low while ready and idle
        if (!busy && rx_en && want) begin
          rts_n <= 1'b0;
        end else if (busy && fall_ev) begin
          rts_n <= 1'b1;
        end
        if (start) begin
          // load word, first bit goes out at once
          busy   <= 1'b1;
          nbits  <= `CSP_ZERO_BITS;
          tx_sh  <= txbuf;
          txd_q  <= msb ? txbuf[7] : txbuf[0];
          sclk_q <= idle_lvl;
          if ((!cont || tx_pend) && !tx_wr) begin
            tx_pend <= 1'b0;            // a write in this cycle stays pending
          end
          if (cont) begin
            rx_arm <= 1'b0;
          end
        end else if (busy) begin
          if (tick) begin
            sclk_q <= ~sclk_q;
          end
          if (shft_ev && nbits != `CSP_ZERO_BITS) begin
            // next bit out on the output edge
            tx_sh <= msb ? {tx_sh[6:0], 1'b0} : {1'b0, tx_sh[7:1]};
            txd_q <= msb ? tx_sh[6] : tx_sh[1];
          end
          if (samp_ev) begin
            rx_sh <= msb ? {rx_sh[6:0], rxd_i}
                         : {rxd_i, rx_sh[7:1]};
            nbits <= nbits + 4'h1;
            if (nbits == `CSP_BIT_SEVENTH && rx_full) begin
              ovr            <= 1'b1;
              ev[`CSP_ST_OVR] <= 1'b1;
            end
          end
          if (last_bit) begin
            // word complete after the eighth sample
            busy  <= 1'b0;
            rxbuf <= msb ? {rx_sh[6:0], rxd_i} : {rxd_i, rx_sh[7:1]};
            rx_full <= 1'b1;
            ev[`CSP_ST_TXDONE] <= 1'b1;
            ev[`CSP_ST_RXDONE] <= rx_en;
          end
        end else begin
          sclk_q <= idle_lvl;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  assign sclk_o    = sclk_q;
  assign sclk_oe_o = mode_on & ~ext_clk;
  assign txd_o     = txd_q;
  assign hs_o      = hs_dis ? port[`CSP_PORT_OUT] : rts_n;
  assign hs_oe_o   = hs_dis ? port[`CSP_PORT_DIR]
                            : (mode_on & rts_sel);

endmodule // csp_serial_port

//--- csp_serial_port_props.sv
// checker for the serial port: bus handshake, link timing, pin use.
// assumes a bind onto csp_serial_port with every port by name.
`include "csp_defines.vh"

module csp_serial_port_props (
  // clock and reset
  input wire        clk_i,
  input wire        rst_i,
  // avalon-mm slave
  input wire [4:0]  avs_address_i,
  input wire        avs_read_i,
  input wire        avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0]  avs_byteenable_i,
  input wire [31:0] avs_readdata_o,
  input wire        avs_waitrequest_o,
  // link pins
  input wire        sclk_i,
  input wire        sclk_o,
  input wire        sclk_oe_o,
  input wire        rxd_i,
  input wire        txd_o,
  input wire        hs_i,
  input wire        hs_o,
  input wire        hs_oe_o,
  input wire        irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // shadow of control state
  // ----------------------------------------------------------------
  logic [12:0] ctrl_q;  // control copy
  logic [7:0]  rate_q;  // divider copy
  logic [1:0]  run_d;   // run history
  logic [3:0]  ntog;    // toggles in word
  int          cnt;     // cycles since toggle
  int          half;    // expected half period
  wire wr_ok  = avs_write_i && !avs_waitrequest_o;
  wire run    = ctrl_q[2:0] == `CSP_MODE_SYNC && !ctrl_q[3];
  wire steady = run && run_d == 2'h3;
  wire cts_on = !ctrl_q[7] && !ctrl_q[6];
  wire rts_on = !ctrl_q[7] && ctrl_q[6] && steady;
  // prescaler times setting plus one
  always @* begin
    case (ctrl_q[5:4])
      2'h1:    half = 8 * (rate_q + 1);
      2'h2:    half = 32 * (rate_q + 1);
      default: half = rate_q + 1;
    endcase
  end
  // track writes and count clock toggles
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= `CSP_CTRL_RST;
      rate_q <= 8'h00;
      run_d  <= 2'h0;
      ntog   <= 4'h0;
      cnt    <= 0;
    end else begin
      if (wr_ok && avs_address_i == `CSP_OFS_CTRL && avs_byteenable_i[0])
        ctrl_q[7:0] <= avs_writedata_i[7:0];
      if (wr_ok && avs_address_i == `CSP_OFS_CTRL && avs_byteenable_i[1])
        ctrl_q[12:8] <= avs_writedata_i[12:8];
      if (wr_ok && avs_address_i == `CSP_OFS_RATE && avs_byteenable_i[0])
        rate_q <= avs_writedata_i[7:0];
      run_d <= {run_d[0], run};
      cnt   <= $changed(sclk_o) ? 1 : cnt + 1;
      if (!steady) ntog <= 4'h0;
      else if ($changed(sclk_o)) ntog <= ntog + 4'h1;
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req_rise; $rose(avs_read_i || avs_write_i); endsequence
  sequence s_one_wait; avs_waitrequest_o ##1 !avs_waitrequest_o; endsequence
  sequence s_edge; steady && $changed(sclk_o) && ntog != 4'h0; endsequence
  sequence s_first_fall; $fell(sclk_o) && ntog == {3'h0, ctrl_q[8]}; endsequence
  sequence s_cts_held; hs_i [*4]; endsequence

  a_one_wait_state: assert property (s_req_rise |-> s_one_wait)
    else $error("bus wait state count wrong");
  a_idle_no_wait: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
    else $error("wait raised without request");
  a_reset_quiet: assert property (disable iff (1'b0)
    rst_i |=> txd_o && !sclk_oe_o && !hs_oe_o && !irq_o)
    else $error("pins not quiet after reset");
  a_mode_gates_clk: assert property (ctrl_q[2:0] != `CSP_MODE_SYNC
    && $past(ctrl_q[2:0]) != `CSP_MODE_SYNC |-> !sclk_oe_o)
    else $error("clock driven outside sync mode");
  a_cts_no_drive: assert property (cts_on && $past(cts_on) |-> !hs_oe_o)
    else $error("handshake pin driven as input");
  a_rts_drives: assert property (rts_on && $past(rts_on) |-> hs_oe_o)
    else $error("handshake pin not driven as output");
  a_half_period: assert property (s_edge |-> cnt == half)
    else $error("transfer clock half period wrong");
  a_txd_hold_sample: assert property (s_edge ##0
    (sclk_o == !ctrl_q[8] && ntog != 4'hf) |-> $stable(txd_o))
    else $error("data changed on sampling edge");
  a_rts_release: assert property (rts_on ##0 s_first_fall |-> ##[0:2] hs_o)
    else $error("ready line not released");
  a_cts_blocks: assert property (s_cts_held ##0
    (cts_on && steady && ntog == 4'h0) |-> $stable(sclk_o))
    else $error("word started while blocked");
endmodule // csp_serial_port_props
